// [core/cache_mem_pkg.sv]
package cache_mem_pkg;
  // memory data port of one slice and its nibble configuration
  localparam int MEM_DATA_W = 8;
  localparam int NIBBLE_W = 4;
  // transfers per line buffer and the burst counter that walks it
  localparam int BURST_DEPTH = 4;
  localparam int CNT_W = $clog2(BURST_DEPTH);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  // synchroniser depth shared by every bit_sync chain, on pins and crossings alike
  localparam int SYNC_STAGES = 2;
  // clock periods in ns, kept for the timing note of the bench
  localparam int REF_CLK_NS = 8;
  localparam int MEM_CLK_NS = 48;
  // drive strength codes as sampled from the shared freeze pin
  localparam logic DRIVE_NORMAL = 1'b1;
  localparam logic DRIVE_HIGH = 1'b0;
  // snoop reporting states
  typedef enum logic [1:0] {
    SN_IDLE = 2'b01,
    SN_HOLD = 2'b10
  } snoop_state_e;
  // link side cycle states
  typedef enum logic [2:0] {
    LK_IDLE = 3'b001,
    LK_BURST = 3'b010,
    LK_FROZEN = 3'b100
  } link_state_e;
endpackage

// [core/snoop_if.sv]
`timescale 1ns/10ps
interface snoop_if;
  // snoop request from the controller core
  logic cycle_n;
  logic lookup_hit;
  logic ready_n;
  // snoop answer toward the memory bus and the writeback scheduler
  logic hit_mod_n;
  logic wb_req;
  modport track (
    input cycle_n,
    input lookup_hit,
    input ready_n,
    output hit_mod_n,
    output wb_req
  );
  modport core (
    output cycle_n,
    output lookup_hit,
    output ready_n,
    input hit_mod_n,
    input wb_req
  );
endinterface

// [core/bit_sync.sv]
`timescale 1ns/10ps
module bit_sync #(
  parameter int WIDTH = 1,
  parameter int STAGES = cache_mem_pkg::SYNC_STAGES
) (
  // destination clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // level from the other domain and its safe copy
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  import cache_mem_pkg::*;
  logic [WIDTH-1:0] stage_q [STAGES];

  // only the last stage is read outside this chain
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < STAGES; i++) stage_q[i] <= '0;
    end else begin
      stage_q[0] <= d;
      for (int i = 1; i < STAGES; i++) stage_q[i] <= stage_q[i-1];
    end
  end

  assign q = stage_q[STAGES-1];
endmodule

// [core/snoop_track.sv]
`timescale 1ns/10ps
module snoop_track (
  // processor clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // snoop request and answer
  snoop_if.track sn
);
  import cache_mem_pkg::*;
  snoop_state_e state_q, state_d;
  logic hit_mod_n_q, hit_mod_n_d;
  logic wb_req_q, wb_req_d;
  wire logic snoop_now = !sn.cycle_n;
  wire logic ready_now = !sn.ready_n;

  // answer is registered, so it is valid one clock after the request
  always_comb begin
    state_d = state_q;
    hit_mod_n_d = hit_mod_n_q;
    wb_req_d = 1'b0;
    unique case (state_q)
      SN_IDLE: begin
        if (snoop_now) begin
          hit_mod_n_d = !sn.lookup_hit;
          if (sn.lookup_hit) begin
            wb_req_d = 1'b1;
            state_d = SN_HOLD;
          end
        end else begin
          hit_mod_n_d = 1'b1;
        end
      end
      SN_HOLD: begin
        // stays low through the ready clock of the writeback
        if (ready_now) begin
          hit_mod_n_d = 1'b1;
          state_d = SN_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= SN_IDLE;
      hit_mod_n_q <= 1'b1;
      wb_req_q <= 1'b0;
    end else begin
      state_q <= state_d;
      hit_mod_n_q <= hit_mod_n_d;
      wb_req_q <= wb_req_d;
    end
  end

  assign sn.hit_mod_n = hit_mod_n_q;
  assign sn.wb_req = wb_req_q;
endmodule

// [core/cache_mem_port.sv]
// Functional notes
// - controller asserts buffer cycle output when the cycle uses memory buffers
// - clocked mode: data moves on memory clock rise only with burst ready; code also captures fill data on end-of-cycle without ready
// - clocked mode: output clock acts as latch enable for write data
// - strobed mode: data moves on strobe or end-of-cycle edges, no clock
// - four-pin configurations use data bits 3..0, upper four unused
// - drive strength sampled at reset release; high normal, low high-drive
// - data pins float while output enable high, driven while low
// - controller ends cycle with end-of-cycle; new cycle allowed at once
// - end-of-cycle latches or drives data and clears burst counter
// - end-of-cycle sampled on clock rise, or its falling edge when strobed
// - freeze with end-of-cycle on write keeps data against allocation
// - line allocated after frozen write is marked modified
// - hit-modified output reports snoop hits to modified lines
// - snoop hit to modified line schedules a writeback by itself
// - hit-modified valid clock after snoop, held until writeback ready
// - clocked: ready with select advances counter and moves next data
// - strobed: input strobe latches and advances, output strobe presents
// - select deassertion clears the burst counter
// - toggling strobe-mode pin after reset selects clocked mode
`timescale 1ns/10ps
module cache_mem_port #(
  parameter int DATA_W = cache_mem_pkg::MEM_DATA_W,
  parameter int DEPTH = cache_mem_pkg::BURST_DEPTH
) (
  // clocks and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic mem_clk,
  // configuration
  input wire logic strobe_mode_cfg,
  input wire logic nibble_mode,
  output logic mem_high_drive,
  // controller cycle control
  input wire logic cycle_req,
  input wire logic cycle_fill,
  output logic buffer_cycle_n,
  output logic cycle_done,
  output logic alloc_modified,
  // drive buffer load and fill buffer read
  input wire logic tx_wr_en,
  input wire logic [cache_mem_pkg::CNT_W-1:0] tx_wr_idx,
  input wire logic [DATA_W-1:0] tx_wr_data,
  input wire logic [cache_mem_pkg::CNT_W-1:0] rx_rd_idx,
  output logic [DATA_W-1:0] rx_rd_data,
  // memory bus control pins
  input wire logic mem_burst_ready_n,
  input wire logic mem_output_latch_clock,
  input wire logic mem_end_of_cycle_n,
  input wire logic mem_chip_select_n,
  input wire logic mem_freeze_n,
  input wire logic mem_data_out_en_n,
  // memory data pins
  input wire logic [DATA_W-1:0] mem_data_in,
  output logic [DATA_W-1:0] mem_data_out,
  output logic mem_data_oe_n,
  // snoop pins
  input wire logic snoop_cycle_n,
  input wire logic snoop_hit_lookup,
  input wire logic controller_ready_n,
  output logic snoop_hit_modified_n,
  output logic snoop_wb_req
);
  import cache_mem_pkg::*;

  // line buffers; each entry written in one domain only
  logic [DATA_W-1:0] tx_mem [DEPTH];
  logic [DATA_W-1:0] rx_mem [DEPTH];
  wire logic [DATA_W-1:0] nib_mask = DATA_W'({NIBBLE_W{1'b1}});

  //////////////////////////////////////////////////////////////////////////
  // processor clock side

  logic buffer_cycle_n_q;
  // settle count: the pin synchronisers leave reset holding zero, so
  // neither the strap nor a mode edge may be judged before they refill
  localparam int SETTLE = SYNC_STAGES + 1;
  localparam int AGE_W = $clog2(SETTLE + 1);
  logic cfg_p_q, clocked_q;
  logic [AGE_W-1:0] age_q;
  logic strength_q;
  logic eoc_tgl_p_q, alloc_tgl_p_q;
  logic done_q, alloc_q;
  logic [DATA_W-1:0] rx_rd_data_q;
  logic cfg_s, frz_ref_s, eoc_tgl_s, alloc_tgl_s;
  logic eoc_tgl_q, alloc_tgl_q;

  bit_sync #(.WIDTH(1)) u_cfg_sync (
    .clk(ref_clk), .rst_b(rst_b), .d(strobe_mode_cfg), .q(cfg_s));
  bit_sync #(.WIDTH(1)) u_frz_ref_sync (
    .clk(ref_clk), .rst_b(rst_b), .d(mem_freeze_n), .q(frz_ref_s));
  bit_sync #(.WIDTH(1)) u_eoc_tgl_sync (
    .clk(ref_clk), .rst_b(rst_b), .d(eoc_tgl_q), .q(eoc_tgl_s));
  bit_sync #(.WIDTH(1)) u_alloc_tgl_sync (
    .clk(ref_clk), .rst_b(rst_b), .d(alloc_tgl_q), .q(alloc_tgl_s));

  // any edge on the mode pin means a clock is running there
  wire logic settled = (age_q == AGE_W'(SETTLE));
  wire logic strap_now = (age_q == AGE_W'(SYNC_STAGES));
  wire logic cfg_edge = settled && (cfg_s != cfg_p_q);
  // loads only while no cycle uses the buffer, so the link reads it stable
  wire logic tx_load = tx_wr_en && !cycle_req;

  // mode, strap and cycle flags
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      buffer_cycle_n_q <= 1'b1;
      cfg_p_q <= 1'b0;
      clocked_q <= 1'b0;
      age_q <= '0;
      strength_q <= DRIVE_NORMAL;
    end else begin
      buffer_cycle_n_q <= !cycle_req;
      cfg_p_q <= cfg_s;
      if (cfg_edge) clocked_q <= 1'b1;
      if (!settled) age_q <= age_q + AGE_W'(1);
      if (strap_now) strength_q <= frz_ref_s;
    end
  end

  // event toggles from the link become one-cycle pulses
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      eoc_tgl_p_q <= 1'b0;
      alloc_tgl_p_q <= 1'b0;
      done_q <= 1'b0;
      alloc_q <= 1'b0;
    end else begin
      eoc_tgl_p_q <= eoc_tgl_s;
      alloc_tgl_p_q <= alloc_tgl_s;
      done_q <= eoc_tgl_s ^ eoc_tgl_p_q;
      alloc_q <= alloc_tgl_s ^ alloc_tgl_p_q;
    end
  end

  // buffer load and readback; arrays carry no reset
  always_ff @(posedge ref_clk) begin
    if (tx_load) tx_mem[tx_wr_idx] <= tx_wr_data;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) rx_rd_data_q <= '0;
    else rx_rd_data_q <= rx_mem[rx_rd_idx];
  end

  assign buffer_cycle_n = buffer_cycle_n_q;
  assign mem_high_drive = (strength_q == DRIVE_HIGH);
  assign cycle_done = done_q;
  assign alloc_modified = alloc_q;
  assign rx_rd_data = rx_rd_data_q;

  //////////////////////////////////////////////////////////////////////////
  // snoop reporting

  snoop_if sn ();
  assign sn.cycle_n = snoop_cycle_n;
  assign sn.lookup_hit = snoop_hit_lookup;
  assign sn.ready_n = controller_ready_n;

  snoop_track u_snoop (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .sn(sn)
  );

  assign snoop_hit_modified_n = sn.hit_mod_n;
  assign snoop_wb_req = sn.wb_req;

  //////////////////////////////////////////////////////////////////////////
  // memory clock side

  logic rst_mem_b;
  logic rdy_n_s, olc_s, eoc_n_s, sel_n_s, frz_n_s;
  logic mode_s, act_s, fill_s, nib_s;
  logic [DATA_W-1:0] data_s;
  logic rdy_p_q, olc_p_q, eoc_p_q, sel_p_q;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [DATA_W-1:0] out_q;
  link_state_e lk_q, lk_d;

  // reset leaves the memory side only in step with its own clock
  bit_sync #(.WIDTH(1)) u_rst_mem_sync (
    .clk(mem_clk), .rst_b(rst_b), .d(1'b1), .q(rst_mem_b));
  bit_sync #(.WIDTH(5)) u_pin_sync (
    .clk(mem_clk), .rst_b(rst_mem_b),
    .d({mem_burst_ready_n, mem_output_latch_clock, mem_end_of_cycle_n,
        mem_chip_select_n, mem_freeze_n}),
    .q({rdy_n_s, olc_s, eoc_n_s, sel_n_s, frz_n_s}));
  bit_sync #(.WIDTH(DATA_W)) u_data_sync (
    .clk(mem_clk), .rst_b(rst_mem_b), .d(mem_data_in), .q(data_s));
  bit_sync #(.WIDTH(4)) u_ctl_sync (
    .clk(mem_clk), .rst_b(rst_mem_b),
    .d({clocked_q, !buffer_cycle_n_q, cycle_fill, nibble_mode}),
    .q({mode_s, act_s, fill_s, nib_s}));

  // event decode; the ready and latch pins double as the two strobes
  wire logic sel_on = !sel_n_s;
  wire logic in_stb_edge = rdy_n_s ^ rdy_p_q;
  wire logic out_stb_edge = olc_s ^ olc_p_q;
  wire logic adv_clk = mode_s && !rdy_n_s && sel_on;
  wire logic adv_in = !mode_s && sel_on && in_stb_edge;
  wire logic adv_out = !mode_s && sel_on && out_stb_edge;
  wire logic advance = act_s && (adv_clk || adv_in || adv_out);
  // clocked takes the sampled level, strobed only the falling edge
  wire logic eoc_ev = mode_s ? !eoc_n_s
                             : (eoc_p_q && !eoc_n_s);
  wire logic sel_drop = sel_n_s && !sel_p_q;
  wire logic frozen = (lk_q == LK_FROZEN);
  // a frozen write locks the fill buffer against the allocation
  wire logic freeze_ev = eoc_ev && act_s && !fill_s && !frz_n_s;
  wire logic capture = act_s && fill_s && !frozen &&
                       (adv_clk || adv_in || eoc_ev);
  wire logic [DATA_W-1:0] cap_data = nib_s ? (data_s & nib_mask)
                                           : data_s;
  wire logic [DATA_W-1:0] tx_word = nib_s ? (tx_mem[cnt_q] & nib_mask)
                                          : tx_mem[cnt_q];
  // clocked: latch enable high lets data through, low holds it
  wire logic present = mode_s ? olc_s
                              : (adv_out || eoc_ev);

  // burst counter: clear wins over advance
  always_comb begin
    cnt_d = cnt_q;
    if (eoc_ev || sel_drop) cnt_d = CNT_ZERO;
    else if (advance) cnt_d = cnt_q + CNT_ONE;
  end

  // cycle state; after an end a new cycle needs no processor sync
  always_comb begin
    lk_d = lk_q;
    unique case (lk_q)
      LK_IDLE: begin
        if (act_s) lk_d = LK_BURST;
      end
      LK_BURST: begin
        if (freeze_ev) lk_d = LK_FROZEN;
        else if (eoc_ev && !act_s) lk_d = LK_IDLE;
        else if (!act_s && !sel_on) lk_d = LK_IDLE;
      end
      LK_FROZEN: begin
        // the allocating fill ends here; line must be kept modified
        if (eoc_ev && act_s && fill_s) lk_d = LK_IDLE;
      end
    endcase
  end

  // edge history and counter
  always_ff @(posedge mem_clk or negedge rst_mem_b) begin
    if (!rst_mem_b) begin
      rdy_p_q <= 1'b1;
      olc_p_q <= 1'b0;
      eoc_p_q <= 1'b1;
      sel_p_q <= 1'b1;
      cnt_q <= CNT_ZERO;
      lk_q <= LK_IDLE;
    end else begin
      rdy_p_q <= rdy_n_s;
      olc_p_q <= olc_s;
      eoc_p_q <= eoc_n_s;
      sel_p_q <= sel_n_s;
      cnt_q <= cnt_d;
      lk_q <= lk_d;
    end
  end

  // drive word and event toggles toward the processor side
  always_ff @(posedge mem_clk or negedge rst_mem_b) begin
    if (!rst_mem_b) begin
      out_q <= '0;
      eoc_tgl_q <= 1'b0;
      alloc_tgl_q <= 1'b0;
    end else begin
      if (act_s && !fill_s && present) out_q <= tx_word;
      if (eoc_ev && act_s) eoc_tgl_q <= !eoc_tgl_q;
      if (frozen && lk_d == LK_IDLE) alloc_tgl_q <= !alloc_tgl_q;
    end
  end

  // fill capture; the processor side reads it back on every ref_clk, not gated by cycle_done
  always_ff @(posedge mem_clk) begin
    if (capture) rx_mem[cnt_q] <= cap_data;
  end

  // enable is a straight path from the pin, no clock in it
  assign mem_data_oe_n = mem_data_out_en_n;
  assign mem_data_out = out_q;
endmodule

// [verif/cache_mem_port_monitor.sv]
`timescale 1ns/10ps
module cache_mem_port_monitor #(
  parameter int DATA_W = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // cycle and snoop pins
  input wire logic cycle_req, cycle_fill, buffer_cycle_n, cycle_done,
  input wire logic alloc_modified, mem_high_drive, mem_end_of_cycle_n,
  input wire logic mem_data_out_en_n, mem_data_oe_n, snoop_cycle_n,
  input wire logic snoop_hit_lookup, controller_ready_n,
  input wire logic snoop_hit_modified_n, snoop_wb_req
);
  logic [2:0] up_q;
  // age since reset; the strap is judged only once settled
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) up_q <= 3'h0;
    else if (up_q != 3'h4) up_q <= up_q + 3'h1;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////
  sequence s_hit_taken;
    !snoop_cycle_n && snoop_hit_lookup && snoop_hit_modified_n;
  endsequence
  sequence s_hit_report;
    !snoop_hit_modified_n && snoop_wb_req ##1 !snoop_wb_req;
  endsequence
  chk_buf_cycle: assert property (cycle_req |=> !buffer_cycle_n)
    else $error("buffer cycle output missing");
  chk_oe_pass: assert property (mem_data_oe_n == mem_data_out_en_n)
    else $error("data enable not passed through");
  chk_strap_hold: assert property (up_q == 3'h4 |-> $stable(mem_high_drive))
    else $error("drive strength changed after reset");
  chk_eoc_done: assert property ($fell(mem_end_of_cycle_n) && !buffer_cycle_n
    |-> ##[1:40] cycle_done)
    else $error("end of cycle not reported");
  chk_done_pulse: assert property (cycle_done |=> !cycle_done)
    else $error("cycle done longer than one clock");
  chk_alloc_fill: assert property (alloc_modified |-> cycle_fill)
    else $error("modified allocation outside a fill");
  chk_snoop_hit: assert property (s_hit_taken |=> s_hit_report)
    else $error("snoop hit not reported");
  chk_snoop_miss: assert property (!snoop_cycle_n && !snoop_hit_lookup &&
    snoop_hit_modified_n |=> snoop_hit_modified_n && !snoop_wb_req)
    else $error("snoop miss reported as hit");
  chk_hitm_hold: assert property (!snoop_hit_modified_n && controller_ready_n
    |=> !snoop_hit_modified_n)
    else $error("hit modified dropped early");
  chk_hitm_free: assert property (!snoop_hit_modified_n && !controller_ready_n
    |=> snoop_hit_modified_n)
    else $error("hit modified held after ready");
  chk_wb_alone: assert property (snoop_wb_req |-> !snoop_hit_modified_n)
    else $error("writeback without hit modified");
endmodule
bind cache_mem_port cache_mem_port_monitor #(.DATA_W(DATA_W), .DEPTH(DEPTH))
  u_mon (.*);

// [verif/mem_bus_model.sv]
`timescale 1ns/10ps
module mem_bus_model (
  // link clock
  input wire logic mem_clk,
  // pins toward the slice
  output logic strobe_mode_cfg, mem_burst_ready_n, mem_output_latch_clock,
  output logic mem_end_of_cycle_n, mem_chip_select_n, mem_freeze_n,
  output logic mem_data_out_en_n,
  // data wire as every party sees it
  output logic [7:0] mem_data_in,
  input wire logic [7:0] mem_data_out,
  input wire logic mem_data_oe_n
);
  logic [7:0] d[4];
  logic [7:0] drv;
  logic [7:0] seen[$];
  logic own, stb;
  // a released wire shows a pattern that moves every link cycle while the mode pin toggles
  assign mem_data_in = !mem_data_oe_n ? mem_data_out :
    own ? drv : {8{strobe_mode_cfg}} ^ 8'h5a;
  initial begin
    {strobe_mode_cfg, mem_burst_ready_n, mem_output_latch_clock} = 3'b010;
    {mem_end_of_cycle_n, mem_chip_select_n, mem_freeze_n} = 3'b111;
    mem_data_out_en_n = 1'b1;
    own = 1'b0;
    stb = 1'b0;
    drv = 8'h00;
  end
  // a running clock on the mode pin selects clocked mode
  always @(posedge mem_clk) if (!stb) strobe_mode_cfg <= ~strobe_mode_cfg;
  // keep each new value the slice presents while the latch is open
  always @(posedge mem_clk)
    if (!mem_data_oe_n && mem_output_latch_clock &&
        (seen.size() == 0 || seen[$] !== mem_data_in))
      seen.push_back(mem_data_in);
  ////////////////////////////////////////////////////////////////////////
  task automatic beat(input logic [7:0] v, input logic rdy_n);
    drv <= v;
    // strobed: a ready beat is one edge of the input strobe
    mem_burst_ready_n <= !stb ? rdy_n :
      rdy_n ? mem_burst_ready_n : ~mem_burst_ready_n;
    @(posedge mem_clk);
  endtask
  // one memory bus cycle, with optional wait states and a deselect
  task automatic run(input logic fill, frz, brk, input int slow);
    int i;
    seen.delete();
    @(posedge mem_clk);
    own <= fill;
    mem_data_out_en_n <= fill;
    mem_output_latch_clock <= ~fill;
    mem_chip_select_n <= 1'b0;
    if (brk) begin
      beat(~d[0], 1'b0);
      beat(~d[1], 1'b0);
      mem_chip_select_n <= 1'b1; // ready stays low, must be ignored
      @(posedge mem_clk);
      mem_chip_select_n <= 1'b0;
    end
    for (i = 0; i < 3; i++) begin
      repeat (slow) beat(d[i], 1'b1);
      beat(d[i], 1'b0);
    end
    mem_end_of_cycle_n <= 1'b0;
    mem_freeze_n <= ~frz;
    beat(d[3], 1'b1);
    mem_end_of_cycle_n <= 1'b1;
    mem_freeze_n <= 1'b1;
    // slice output lags the pins through its synchronisers
    repeat (4) @(posedge mem_clk);
    {mem_chip_select_n, mem_data_out_en_n, own} <= 3'b110;
    mem_output_latch_clock <= 1'b0;
    repeat (2) @(posedge mem_clk);
  endtask
endmodule

// [verif/cache_mem_port_tb_top.sv]
`timescale 1ns/10ps
module cache_mem_port_tb_top;
  import cache_mem_pkg::*;
  logic ref_clk = 1'b0, mem_clk = 1'b0, rst_b = 1'b0;
  logic nibble_mode, cycle_req, cycle_fill, tx_wr_en, mem_high_drive;
  logic [CNT_W-1:0] tx_wr_idx, rx_rd_idx;
  logic [7:0] tx_wr_data, rx_rd_data, mem_data_in, mem_data_out;
  logic buffer_cycle_n, cycle_done, alloc_modified, mem_data_oe_n;
  logic strobe_mode_cfg, mem_burst_ready_n, mem_output_latch_clock;
  logic mem_end_of_cycle_n, mem_chip_select_n, mem_freeze_n;
  logic mem_data_out_en_n, snoop_cycle_n, snoop_hit_lookup;
  logic controller_ready_n, snoop_hit_modified_n, snoop_wb_req;
  logic lk;
  logic [7:0] rx_exp[4];
  int err_total = 0, tests_run = 0, n_done = 0, n_alloc = 0;
  cache_mem_port #(.DATA_W(8), .DEPTH(4)) DUT (.*);
  mem_bus_model bus (.*);
  always #4 ref_clk = ~ref_clk;
  always #24 mem_clk = ~mem_clk;
  always @(posedge ref_clk) begin
    n_done += int'(cycle_done === 1'b1);
    n_alloc += int'(alloc_modified === 1'b1);
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [7:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic give_verdict;
    if (err_total == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic logic [7:0] exp_byte(input logic [7:0] v, input logic n);
    exp_byte = n ? {4'h0, v[3:0]} : v;
  endfunction
  function automatic logic has(input logic [7:0] v);
    has = 1'b0;
    foreach (bus.seen[j]) if (bus.seen[j] === v) has = 1'b1;
  endfunction
  // freeze pin doubles as the drive strength strap at reset release
  task automatic do_reset(input logic strap);
    bus.mem_freeze_n <= strap;
    rst_b <= 1'b0;
    lk = 1'b0;
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge ref_clk);
    check("high_drive", {7'h0, mem_high_drive}, {7'h0, ~strap});
    bus.mem_freeze_n <= 1'b1;
    repeat (40) @(posedge ref_clk);
  endtask
  task automatic burst(input logic fill, frz, brk, nib);
    int i, k;
    nibble_mode <= nib;
    cycle_fill <= fill;
    for (i = 0; i < 4; i++) begin
      k = $urandom;
      bus.d[i] = {k[5:0], i[1:0]};
      tx_wr_en <= 1'b1;
      tx_wr_idx <= i[1:0];
      tx_wr_data <= bus.d[i];
      if (fill && !lk) rx_exp[i] = exp_byte(bus.d[i], nib);
      @(posedge ref_clk);
    end
    // loads while the cycle runs must be refused
    cycle_req <= 1'b1;
    tx_wr_data <= ~bus.d[3];
    repeat (2) @(posedge ref_clk);
    tx_wr_en <= 1'b0;
    check("buffer_cycle", {7'h0, buffer_cycle_n}, 8'h00);
    n_done = 0;
    n_alloc = 0;
    repeat (4) @(posedge mem_clk);
    bus.run(fill, frz, brk, $urandom_range(2));
    for (k = 0; k < 200 && n_done == 0; k++) @(posedge ref_clk);
    repeat (8) @(posedge ref_clk);
    cycle_req <= 1'b0;
    check("cycle_done", n_done[7:0], 8'h01);
    check("alloc_mod", n_alloc[7:0], {7'h0, fill & lk});
    if (fill) lk = 1'b0;
    else if (frz) lk = 1'b1;
    for (i = 0; i < 4; i++) begin
      rx_rd_idx <= i[1:0];
      repeat (3) @(posedge ref_clk);
      if (fill) check("fill_data", rx_rd_data, rx_exp[i]);
      else check("drive_data", {7'h0, has(bus.d[i])}, 8'h01);
    end
  endtask
  // one snoop; a second request during the hold must be ignored
  task automatic snoop(input logic hit, input int n);
    snoop_cycle_n <= 1'b0;
    snoop_hit_lookup <= hit;
    @(posedge ref_clk);
    snoop_hit_lookup <= 1'b0;
    @(negedge ref_clk);
    check("hit_mod", {7'h0, snoop_hit_modified_n}, {7'h0, ~hit});
    check("wb_req", {7'h0, snoop_wb_req}, {7'h0, hit});
    @(posedge ref_clk);
    snoop_cycle_n <= 1'b1;
    repeat (n + 1) @(posedge ref_clk);
    check("hit_hold", {7'h0, snoop_hit_modified_n}, {7'h0, ~hit});
    controller_ready_n <= 1'b0;
    @(posedge ref_clk);
    controller_ready_n <= 1'b1;
    @(negedge ref_clk);
    check("hit_free", {7'h0, snoop_hit_modified_n}, 8'h01);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    int k, i;
    {nibble_mode, cycle_req, cycle_fill, tx_wr_en} = 4'h0;
    {tx_wr_idx, rx_rd_idx, tx_wr_data} = '0;
    {snoop_cycle_n, snoop_hit_lookup, controller_ready_n} = 3'b101;
    k = $urandom(32'h7f7b496e);
    do_reset(1'b0);
    burst(1'b1, 1'b0, 1'b1, 1'b0);
    burst(1'b0, 1'b0, 1'b0, 1'b0);
    burst(1'b0, 1'b1, 1'b0, 1'b0);
    burst(1'b1, 1'b0, 1'b0, 1'b1);
    burst(1'b1, 1'b0, 1'b0, 1'b1);
    for (i = 0; i < 8; i++) begin
      k = $urandom;
      burst(k[0], !k[0] & k[1], k[0] & k[2], k[0] & k[3]);
      snoop(k[4], int'(k[7:5]));
    end
    do_reset(1'b1);
    snoop(1'b1, 0);
    burst(1'b1, 1'b0, 1'b0, 1'b0);
    // mode pin held still from reset on: strobed fill
    bus.stb = 1'b1;
    do_reset(1'b1);
    burst(1'b1, 1'b0, 1'b0, 1'b0);
    give_verdict();
  end
  // watchdog well beyond the expected run
  initial begin
    repeat (60000) @(posedge ref_clk);
    err_total++;
    give_verdict();
  end
endmodule
